/* File: dv/eep_bus_master.sv */
`timescale 1ns/1ns
// ********************************************
// Bus master model: drives SCL, pulls SDA low
// ********************************************
module eep_bus_master (
    input  wire logic       clk,
    input  wire logic       sdaLine,
    output logic            sclPin,
    output logic            sdaPull,
    output logic            resValid,
    output logic [7:0]      resData
);
    // Idle bus: clock parked high, data released
    initial begin
        sclPin   = 1'h1;
        sdaPull  = 1'h0;
        resValid = 1'h0;
        resData  = 8'h00;
    end
    // Wait n clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One result for the bench watcher, one cycle wide
    task automatic publish(input logic [7:0] v);
        resData  <= v;
        resValid <= 1'h1;
        tick(1);
        resValid <= 1'h0;
    endtask
    // Data moves mid low phase; SCL high four cycles
    task automatic bitOut(input logic b);
        sdaPull <= ~b;
        tick(2);
        sclPin <= 1'h1;
        tick(4);
        sclPin <= 1'h0;
        tick(2);
    endtask
    // Released line, sampled mid high phase
    task automatic bitIn(output logic b);
        sdaPull <= 1'h0;
        tick(2);
        sclPin <= 1'h1;
        tick(2);
        b = sdaLine;
        tick(2);
        sclPin <= 1'h0;
        tick(2);
    endtask
    // Start; repeated Start when the clock is parked low
    task automatic start();
        if (sclPin == 1'h0) begin
            sdaPull <= 1'h0;
            tick(2);
            sclPin <= 1'h1;
            tick(4);
        end
        sdaPull <= 1'h1;
        tick(4);
        sclPin <= 1'h0;
        tick(2);
    endtask
    // Stop; clock then stands high until the next frame
    task automatic stop();
        sdaPull <= 1'h1;
        tick(2);
        sclPin <= 1'h1;
        tick(4);
        sdaPull <= 1'h0;
        tick(8);
    endtask
    // MSB first, then the ack slot is read back
    task automatic wrByte(input logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) bitOut(d[i]);
        bitIn(b);
        publish({7'h00, ~b});
    endtask
    // Eight bits in, then our ack or no-ack
    task automatic rdByte(input logic ackIt);
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) bitIn(d[i]);
        publish(d);
        bitOut(~ackIt);
    endtask
endmodule

/* File: dv/i2c_serial_eeprom_access_bench.sv */
`timescale 1ns/1ns
module i2c_serial_eeprom_access_bench;
    import eep_pkg::*;
    // ********************************************
    // Signals; short write cycle outlasts one poll
    // ********************************************
    localparam int unsigned PROG = 200;
    logic        clk       = 1'h0;
    logic        resetn    = 1'h0;
    logic        wp        = 1'h0;  // Write-protect pin
    logic [2:0]  cs        = 3'h5;  // Strapped select bits
    logic        sclPin;
    logic        mPull;             // Master pulls SDA
    logic        resValid;
    logic [7:0]  resData;
    logic        sdaOut;
    logic        sdaOe;
    logic        progBusy;
    wire         sdaLine   = ~((sdaOe & ~sdaOut) | mPull); // Pull-up
    logic [7:0]  q[$];              // Expected results, oldest first
    logic [7:0]  mirror[8192];      // Expected array contents
    logic [15:0] seed      = 16'h5d7a;
    int          bad_count = 0;
    int          checks    = 0;
    int          cycles    = 0;

    eep_i2c_slave #(.PROG_CYCLES(PROG)) dut (.clk(clk), .resetn(resetn),
        .sclIn(sclPin), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .chipSelectBit0(cs[0]), .chipSelectBit1(cs[1]),
        .chipSelectBit2(cs[2]), .writeProtect(wp), .progBusy(progBusy));
    eep_bus_master mst (.clk(clk), .sdaLine(sdaLine), .sclPin(sclPin),
        .sdaPull(mPull), .resValid(resValid), .resData(resData));

    always #10 clk = ~clk;
    // Hang guard, well above the expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // ********************************************
    // Checking
    // ********************************************
    task automatic report_and_stop();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmpRes(input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (exp !== got) begin
            bad_count++;
            $display("[FAIL] %0t bus exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic cmpFlag(input logic exp, input logic got);
        checks++;
        if (exp !== got) begin
            bad_count++;
            $display("[FAIL] %0t flag exp %b got %b", $time, exp, got);
        end
    endtask
    // Watcher: every published result meets the oldest note
    always @(posedge clk) begin
        if (resValid === 1'h1) begin
            if (q.size() == 0) cmpRes(8'hxx, resData);
            else cmpRes(q.pop_front(), resData);
        end
    end
    // ********************************************
    // Stimulus helpers
    // ********************************************
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction
    task automatic sendB(input logic [7:0] b, input logic ack);
        q.push_back({7'h00, ack});
        mst.wrByte(b);
    endtask
    task automatic ctrl(input logic rd, input logic ack);
        mst.start();
        sendB({EEP_DEV_TYPE, cs, rd}, ack);
    endtask
    // Top three bits sent as given; 16'hfffe sets them, they must be ignored
    task automatic setAddr(input logic [15:0] a);
        ctrl(1'h0, 1'h1);
        sendB(a[15:8], 1'h1);
        sendB(a[7:0], 1'h1);
    endtask
    // Only the low five pointer bits advance per byte
    task automatic pageWr(input logic [15:0] a, input int n, input logic pr);
        logic [7:0] d;
        setAddr(a);
        for (int i = 0; i < n; i++) begin
            d = rnd();
            sendB(d, 1'h1);
            if (!pr) mirror[{a[12:5], a[4:0] + i[4:0]}] = d;
        end
        mst.stop();
    endtask
    // Busy right after Stop, poll refused, then accepted
    task automatic waitProg();
        int k;
        mst.tick(4);
        cmpFlag(1'h1, progBusy);
        ctrl(1'h0, 1'h0);
        mst.stop();
        k = 0;
        while (progBusy !== 1'h0 && k < 1000) begin
            mst.tick(1);
            k++;
        end
        ctrl(1'h0, 1'h1);
        mst.stop();
    endtask
    task automatic rdRun(input logic [12:0] p, input int n);
        ctrl(1'h1, 1'h1);
        for (int i = 0; i < n; i++) begin
            q.push_back(mirror[p]);
            mst.rdByte(i < n - 1);
            p = p + 13'h0001;
        end
        mst.stop();
        cmpFlag(1'h0, sdaOe);
    endtask
    // ********************************************
    // Main sequence
    // ********************************************
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        mst.tick(10);
        mst.start();
        sendB({EEP_DEV_TYPE, ~cs, 1'h0}, 1'h0);
        mst.stop();
        mst.start();
        sendB({~EEP_DEV_TYPE, cs, 1'h1}, 1'h0);
        mst.stop();
        setAddr(16'h0123);
        mst.stop();
        mst.tick(6);
        cmpFlag(1'h0, progBusy);
        // Pin raised after Stop must not cancel the cycle
        pageWr(16'h0001, 1, 1'h0);
        wp <= 1'h1;
        waitProg();
        // Protected write: acked, no cycle, ready at once
        pageWr(16'h0001, 1, 1'h1);
        mst.tick(6);
        cmpFlag(1'h0, progBusy);
        ctrl(1'h0, 1'h1);
        mst.stop();
        wp <= 1'h0;
        pageWr(16'h0000, 1, 1'h0);
        waitProg();
        rdRun(13'h0001, 1);
        pageWr(16'hfffe, 4, 1'h0);
        waitProg();
        pageWr(16'h0040, 34, 1'h0);
        waitProg();
        setAddr(16'h1ffe);
        rdRun(13'h1ffe, 3);
        rdRun(13'h0001, 1);
        // New strap value: the old select bits are now foreign
        cs <= 3'h2;
        mst.start();
        sendB({EEP_DEV_TYPE, 3'h5, 1'h1}, 1'h0);
        mst.stop();
        setAddr(16'h1fe0);
        rdRun(13'h1fe0, 2);
        setAddr(16'h0040);
        rdRun(13'h0040, 32);
        report_and_stop();
    end
endmodule

/* File: hdl/eep_i2c_slave.sv */
`timescale 1ns/1ns
// Behaviour
// - Respond only when type and select bits match
// - Address high byte first, thirteen bits used
// - Byte write: control, two addresses, data, acked
// - Stop after write starts programming, no ack
// - Protected write acked, nothing programmed, ready
// - Pointer follows last written byte
// - Page bytes buffered, programmed at Stop
// - Write data bumps only low five bits
// - Buffer position wraps, later bytes overwrite
// - Page overflow wraps to page start
// - Protect pin blocks programming of whole array
// - Protect pin sampled at Stop only
// - Busy device ignores polls, acks when done
// - Current read returns byte after last access
// - Read control acked, eight bits driven
// - Random read pointer set before repeated Start
// - Pointer follows byte read
// - Master ack fetches next byte in order
// - Sequential read wraps top to zero
// - Reads stay in own address space
// - Release data line after master no-ack
module eep_i2c_slave #(
    parameter int unsigned PROG_CYCLES = eep_pkg::EEP_PROG_CYCLES_DEF
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic sclIn,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaOe,
    input  wire logic chipSelectBit0,
    input  wire logic chipSelectBit1,
    input  wire logic chipSelectBit2,
    input  wire logic writeProtect,
    output logic      progBusy
);
    import eep_pkg::*;

    // ***********************************************************
    // Storage
    // ***********************************************************
    logic [7:0]  memArray [EEP_MEM_WORDS];   // Main array
    logic [7:0]  pageBuf  [EEP_PAGE_BYTES];  // Page write buffer

    // ***********************************************************
    // State
    // ***********************************************************
    logic [5:0]  sync1_q;        // First synchroniser stage
    logic [5:0]  sync2_q;        // Second synchroniser stage
    logic        sclPrev_q;      // Clock level one cycle ago
    logic        sdaPrev_q;      // Data level one cycle ago
    eep_state_e  state_q;        // Protocol state
    eep_state_e  state_d;        // Next protocol state
    logic [3:0]  bitCnt_q;       // Rising clock edges in frame
    logic [7:0]  shiftIn_q;      // Received byte
    logic        ctrlHit_q;      // Control byte was acked
    logic        ackDrive_q;     // Pulling data low for ack
    logic        txOn_q;         // Sending read data
    logic [7:0]  txByte_q;       // Read byte, MSB on the line
    logic        masterAck_q;    // Master acked last read byte
    logic [12:0] ptr_q;          // Address pointer
    logic [31:0] bufMask_q;      // Buffered byte positions
    logic [31:0] progMask_q;     // Positions being programmed
    logic        busy_q;         // Programming in progress
    logic [19:0] progCnt_q;      // Programming cycle counter

    // ***********************************************************
    // Decoded events
    // ***********************************************************
    logic        sclS;           // Synchronised clock
    logic        sdaS;           // Synchronised data
    logic        wpS;            // Synchronised write protect
    logic [2:0]  csS;            // Synchronised strap inputs
    logic        sclRise;        // Clock rising edge
    logic        sclFall;        // Clock falling edge
    logic        startEvt;       // Start or repeated Start
    logic        stopEvt;        // Stop
    logic        byteDone;       // Fall after eighth bit
    logic        ackDone;        // Fall after ninth bit
    logic        inWrite;        // Receiving address or data
    logic        ctrlMatch;      // Control byte addresses us
    logic        ackNow;         // Begin driving an ack
    logic        capHigh;        // Take address high byte
    logic        capLow;         // Take address low byte
    logic        storeData;      // Buffer one data byte
    logic        wrOpen;         // Write command accepted
    logic        loadTx;         // Fetch next read byte
    logic        endRead;        // Master ended the read
    logic        progStart;      // Begin programming cycle
    logic        progWrite;      // Copy one buffered byte
    logic        progLast;       // Final programming cycle
    logic [7:0]  rdByte;         // Array byte at pointer
    logic [19:0] progEnd;        // Last counter value

    // Pointer step with the array size wrap
    function automatic logic [12:0] ptrNext(input logic [12:0] p);
        ptrNext = p + 13'h0001;
    endfunction

    // ***********************************************************
    // Input synchronisers
    // ***********************************************************
    // All pins are asynchronous to clk, two stages each
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_q   <= 6'h3F;
            sync2_q   <= 6'h3F;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sync1_q   <= {writeProtect, chipSelectBit2, chipSelectBit1,
                          chipSelectBit0, sdaIn, sclIn};
            sync2_q   <= sync1_q;
            sclPrev_q <= sync2_q[0];
            sdaPrev_q <= sync2_q[1];
        end
    end

    assign sclS     = sync2_q[0];
    assign sdaS     = sync2_q[1];
    assign csS      = sync2_q[4:2];
    assign wpS      = sync2_q[5];
    assign sclRise  = sclS & ~sclPrev_q;
    assign sclFall  = ~sclS & sclPrev_q;
    // Data edges count only while the clock stays high
    assign startEvt = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    assign stopEvt  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

    // ***********************************************************
    // Frame decode
    // ***********************************************************
    assign byteDone  = sclFall && (bitCnt_q == EEP_BIT_ACK);
    assign ackDone   = sclFall && (bitCnt_q == EEP_BIT_END);
    assign inWrite   = (state_q == ST_ADRH) || (state_q == ST_ADRL) ||
                       (state_q == ST_WDATA);
    // Busy device answers no control byte at all
    assign ctrlMatch = (shiftIn_q[7:4] == EEP_DEV_TYPE) &&
                       (shiftIn_q[3:1] == csS) && !busy_q;
    assign ackNow    = byteDone && (((state_q == ST_CTRL) && ctrlMatch) ||
                       inWrite);
    assign capHigh   = byteDone && (state_q == ST_ADRH);
    assign capLow    = byteDone && (state_q == ST_ADRL);
    assign storeData = byteDone && (state_q == ST_WDATA);
    assign wrOpen    = byteDone && (state_q == ST_CTRL) && ctrlMatch &&
                       !shiftIn_q[0];
    assign loadTx    = ackDone && (((state_q == ST_CTRL) && ctrlHit_q &&
                       shiftIn_q[0]) || ((state_q == ST_RDATA) &&
                       masterAck_q));
    assign endRead   = ackDone && (state_q == ST_RDATA) && !masterAck_q;
    // Protect level and empty buffer both veto the cycle
    assign progStart = stopEvt && (bufMask_q != EEP_MASK_RST) && !wpS &&
                       !busy_q;
    assign rdByte    = memArray[ptr_q];

    // ***********************************************************
    // Protocol state machine
    // ***********************************************************
    // Start and Stop override whatever byte is in flight
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_CTRL: begin
                if (ackDone) begin
                    if (!ctrlHit_q) begin
                        state_d = ST_IGNORE;
                    end else if (shiftIn_q[0]) begin
                        state_d = ST_RDATA;
                    end else begin
                        state_d = ST_ADRH;
                    end
                end
            end
            ST_ADRH: begin
                if (ackDone) begin
                    state_d = ST_ADRL;
                end
            end
            ST_ADRL: begin
                if (ackDone) begin
                    state_d = ST_WDATA;
                end
            end
            ST_RDATA: begin
                if (endRead) begin
                    state_d = ST_IGNORE;
                end
            end
            default: begin
                state_d = state_q;
            end
        endcase
        if (startEvt) begin
            state_d = ST_CTRL;
        end else if (stopEvt) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ***********************************************************
    // Bit counter and receive shifter
    // ***********************************************************
    always_ff @(posedge clk) begin
        if (!resetn || startEvt) begin
            bitCnt_q <= 4'h0;
        end else if (ackDone) begin
            bitCnt_q <= 4'h0;
        end else if (sclRise && (bitCnt_q != EEP_BIT_END)) begin
            bitCnt_q <= bitCnt_q + 4'h1;
        end
    end

    // Sample on rising clock, data is stable while high
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shiftIn_q <= 8'h00;
        end else if (sclRise && (bitCnt_q < EEP_BIT_ACK)) begin
            shiftIn_q <= {shiftIn_q[6:0], sdaS};
        end
    end

    // Latch the decision so a late busy change cannot split it
    always_ff @(posedge clk) begin
        if (!resetn || startEvt) begin
            ctrlHit_q <= 1'b0;
        end else if (byteDone && (state_q == ST_CTRL)) begin
            ctrlHit_q <= ctrlMatch;
        end
    end

    // ***********************************************************
    // Data line drive
    // ***********************************************************
    // Ack is held low from the eighth fall to the ninth fall
    always_ff @(posedge clk) begin
        if (!resetn || startEvt || stopEvt) begin
            ackDrive_q <= 1'b0;
        end else if (ackNow) begin
            ackDrive_q <= 1'b1;
        end else if (ackDone) begin
            ackDrive_q <= 1'b0;
        end
    end

    // Read byte shifts out MSB first on each falling clock
    always_ff @(posedge clk) begin
        if (!resetn || startEvt || stopEvt) begin
            txOn_q   <= 1'b0;
            txByte_q <= 8'h00;
        end else if (loadTx) begin
            txOn_q   <= 1'b1;
            txByte_q <= rdByte;
        end else if (byteDone && (state_q == ST_RDATA)) begin
            txOn_q   <= 1'b0;
        end else if (sclFall && txOn_q) begin
            txByte_q <= {txByte_q[6:0], 1'b0};
        end
    end

    // Master answer sampled on the ninth rising clock
    always_ff @(posedge clk) begin
        if (!resetn || startEvt) begin
            masterAck_q <= 1'b0;
        end else if (sclRise && (bitCnt_q == EEP_BIT_ACK) &&
                     (state_q == ST_RDATA)) begin
            masterAck_q <= ~sdaS;
        end
    end

    // Open drain: only ever pull low
    assign sdaOut   = 1'b0;
    assign sdaOe    = ackDrive_q | (txOn_q & ~txByte_q[7]);
    assign progBusy = busy_q;

    // ***********************************************************
    // Address pointer
    // ***********************************************************
    // Thirteen bits only, so reads never leave this array
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ptr_q <= EEP_PTR_RST;
        end else if (capHigh) begin
            ptr_q[12:8] <= shiftIn_q[4:0];
        end else if (capLow) begin
            ptr_q[7:0] <= shiftIn_q;
        end else if (storeData) begin
            ptr_q[4:0] <= ptr_q[4:0] + 5'h01;
        end else if (loadTx) begin
            ptr_q <= ptrNext(ptr_q);
        end
    end

    // ***********************************************************
    // Page buffer
    // ***********************************************************
    // Position wraps, so a long burst keeps the last page bytes
    always_ff @(posedge clk) begin
        if (storeData) begin
            pageBuf[ptr_q[4:0]] <= shiftIn_q;
        end
    end

    // Mask clears at every Stop; progMask keeps the copy
    always_ff @(posedge clk) begin
        if (!resetn || wrOpen || stopEvt) begin
            bufMask_q <= EEP_MASK_RST;
        end else if (storeData) begin
            bufMask_q[ptr_q[4:0]] <= 1'b1;
        end
    end

    // ***********************************************************
    // Self-timed programming
    // ***********************************************************
    // First 32 cycles copy the page, the rest only wait
    assign progEnd   = 20'(PROG_CYCLES - 1);
    assign progLast  = busy_q && (progCnt_q == progEnd);
    assign progWrite = busy_q && (progCnt_q < 20'(EEP_PAGE_BYTES)) &&
                       progMask_q[progCnt_q[4:0]];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_q     <= 1'b0;
            progCnt_q  <= EEP_CNT_RST;
            progMask_q <= EEP_MASK_RST;
        end else if (progStart) begin
            busy_q     <= 1'b1;
            progCnt_q  <= EEP_CNT_RST;
            progMask_q <= bufMask_q;
        end else if (progLast) begin
            busy_q     <= 1'b0;
        end else if (busy_q) begin
            progCnt_q  <= progCnt_q + 20'h0_0001;
        end
    end

    // Pointer upper bits are frozen while busy
    always_ff @(posedge clk) begin
        if (progWrite) begin
            memArray[{ptr_q[12:5], progCnt_q[4:0]}] <=
                pageBuf[progCnt_q[4:0]];
        end
    end

    // ***********************************************************
    // Assertions
    // ***********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_CTRL_MATCH: assert property (
        $rose(ackDrive_q) && (state_q == ST_CTRL) |->
            ($past(shiftIn_q[7:4]) == EEP_DEV_TYPE) &&
            ($past(shiftIn_q[3:1]) == $past(csS)))
        else $error("Control byte acked without a match");
    AST_ADDR_HIGH: assert property (
        capHigh |=> ptr_q[12:8] == $past(shiftIn_q[4:0]))
        else $error("High address byte not taken");
    AST_BUSY_NOACK: assert property (
        byteDone && busy_q && (state_q == ST_CTRL) |=> !sdaOe)
        else $error("Ack given during programming");
    AST_PROG_START: assert property (
        stopEvt && !busy_q && (bufMask_q != EEP_MASK_RST) && !wpS
            |=> busy_q [*8])
        else $error("Write Stop did not start programming");
    AST_WP_BLOCK: assert property (
        stopEvt && wpS && !busy_q |=> !busy_q)
        else $error("Protected write started programming");
    AST_EMPTY_STOP: assert property (
        stopEvt && !busy_q && (bufMask_q == EEP_MASK_RST) |=> !busy_q)
        else $error("Empty write started programming");
    AST_LOW5_INC: assert property (
        storeData |=> (ptr_q[12:5] == $past(ptr_q[12:5])) &&
            (ptr_q[4:0] == $past(ptr_q[4:0]) + 5'h01))
        else $error("Write pointer step wrong");
    AST_READ_INC: assert property (
        loadTx |=> (ptr_q == $past(ptr_q) + 13'h0001) &&
            (txByte_q == $past(rdByte)))
        else $error("Read pointer step wrong");
    AST_NACK_REL: assert property (
        endRead |=> !sdaOe [*2])
        else $error("Data line held after no-ack");

    COV_PAGE_PROG: cover property (progStart && bufMask_q[31]);
    COV_SEQ_READ:  cover property (loadTx && (state_q == ST_RDATA));
    COV_POLL_NAK:  cover property (byteDone && busy_q &&
                                   (state_q == ST_CTRL));
    COV_TOP_WRAP:  cover property (loadTx && (ptr_q == 13'h1FFF));

endmodule

/* File: hdl/eep_pkg.sv */
package eep_pkg;

    // ***********************************************************
    // Array and page geometry
    // ***********************************************************
    localparam int unsigned EEP_ADDR_W     = 13;    // Byte address width
    localparam int unsigned EEP_DATA_W     = 8;     // Data byte width
    localparam int unsigned EEP_PAGE_W     = 5;     // Offset inside a page
    localparam int unsigned EEP_PAGE_BYTES = 32;    // Page buffer depth
    localparam int unsigned EEP_MEM_WORDS  = 8192;  // Array depth

    // ***********************************************************
    // Control byte decode
    // ***********************************************************
    // Device-type code; the value is arbitrary
    localparam logic [3:0]  EEP_DEV_TYPE   = 4'h6;

    // ***********************************************************
    // Bit counter landmarks inside one byte frame
    // ***********************************************************
    localparam logic [3:0]  EEP_BIT_ACK    = 4'h8;  // Eight bits clocked
    localparam logic [3:0]  EEP_BIT_END    = 4'h9;  // Ninth clock seen

    // ***********************************************************
    // Reset values
    // ***********************************************************
    localparam logic [12:0] EEP_PTR_RST    = 13'h0000;
    localparam logic [31:0] EEP_MASK_RST   = 32'h0000_0000;
    localparam logic [19:0] EEP_CNT_RST    = 20'h0_0000;

    // ***********************************************************
    // Self-timed programming length, in clk cycles
    // ***********************************************************
    localparam int unsigned EEP_PROG_CYCLES_DEF = 8192;

    // ***********************************************************
    // Protocol states, Gray coded along the usual path
    // ***********************************************************
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,   // Bus free or waiting for Start
        ST_CTRL   = 3'h1,   // Receiving control byte
        ST_ADRH   = 3'h3,   // Receiving address high byte
        ST_ADRL   = 3'h2,   // Receiving address low byte
        ST_WDATA  = 3'h6,   // Receiving write data
        ST_RDATA  = 3'h7,   // Sending read data
        ST_IGNORE = 3'h5    // Not addressed, wait for Start/Stop
    } eep_state_e;

endpackage
